// file: rtl/interrupt_request_recognition.sv
`timescale 1ns/1ps
module interrupt_request_recognition
   import irq_recog_pkg::*;
#(
   parameter int TIMEOUT_CYC = ACK_TIMEOUT_CYC
)(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic [7:1]  request_lines_n_in,
   input  wire logic [7:1]  internal_req_in,
   input  wire logic        boundary_in,
   input  wire logic        exc_done_in,
   input  wire logic        mask_wr_in,
   input  wire logic [2:0]  mask_wr_data_in,
   input  wire logic        size_ack_strobes_in,
   input  wire logic        autovector_request_in,
   input  wire logic [7:0]  vector_data_in,
   output logic [2:0]       priority_mask_field_out,
   output logic             ack_active_out,
   output logic [2:0]       function_code_lines_out,
   output logic [23:0]      ack_addr_out,
   output logic             vector_valid_out,
   output logic [7:0]       vector_out,
   output logic             spurious_out,
   output logic [7:1]       pending_out
);
   logic [7:1]  line_asserted;
   logic        fall_phase_q;
   logic        fall_phase_d;
   logic [2:0]  mask_q;
   logic [2:0]  mask_d;
   logic        nmi_prev_q;
   logic        nmi_prev_d;
   logic        nmi_pend_q;
   logic        nmi_pend_d;
   logic [2:0]  mask_prev_q;
   logic [2:0]  mask_prev_d;
   ack_state_t  state_q;
   ack_state_t  state_d;
   logic        ack_q;
   logic        ack_d;
   logic [2:0]  ack_level_q;
   logic [2:0]  ack_level_d;
   logic [7:0]  tmo_q;
   logic [7:0]  tmo_d;
   logic [2:0]  fc_q;
   logic [2:0]  fc_d;
   logic [23:0] addr_q;
   logic [23:0] addr_d;
   logic        vvalid_q;
   logic        vvalid_d;
   logic [7:0]  vec_q;
   logic [7:0]  vec_d;
   logic        spur_q;
   logic        spur_d;
   logic [7:1]  pend_q;
   logic [7:1]  pend_d;
   logic [7:1]  eligible;
   logic [2:0]  best_level;

   // highest set level of a request vector, zero when none
   function automatic logic [2:0] top_level(input logic [7:1] req);
      logic [2:0] lvl;
      lvl = MASK_NONE;
      for (int i = 1; i <= NUM_LEVELS; i++)
      begin
         if (req[i])
         begin
            lvl = 3'(i);
         end
      end
      return lvl;
   endfunction : top_level

   // an acknowledge may start only from idle at a boundary or when exception processing is done
   function automatic logic take_point(input ack_state_t st,
                                       input logic       bnd,
                                       input logic       exc);
      return st == ST_IDLE && (bnd || exc);
   endfunction : take_point

   // samples taken every other cycle stand in for the falling edges
   always_comb
   begin
      fall_phase_d = ~fall_phase_q;
   end

   // internal sources merge after the pin path, so pins stay untouched
   genvar g;
   generate
      for (g = 1; g <= NUM_LEVELS; g++)
      begin : g_line
         request_qualifier #(
            .VALID_LEN       (VALID_PERIODS)
         ) u_qual (
            .clk_in          (clk_in),
            .arst_n_in       (arst_n_in),
            .sample_en_in    (fall_phase_q),
            .pin_n_in        (request_lines_n_in[g]),
            .internal_req_in (internal_req_in[g]),
            .asserted_out    (line_asserted[g])
         );
      end
   endgenerate

   always_comb
   begin
      eligible = '0;
      for (int i = 1; i < NUM_LEVELS; i++)
      begin
         eligible[i] = line_asserted[i] && (3'(i) > mask_q);
      end
      eligible[LEVEL_NMI] = nmi_pend_q && line_asserted[LEVEL_NMI];
      best_level = top_level(eligible);
   end

   always_comb
   begin
      nmi_prev_d  = line_asserted[LEVEL_NMI];
      mask_prev_d = mask_q;
      nmi_pend_d  = nmi_pend_q;
      // new assertion of seven, or mask leaving seven while held
      if ((line_asserted[LEVEL_NMI] && !nmi_prev_q) ||
          (line_asserted[LEVEL_NMI] && mask_prev_q == LEVEL_NMI &&
           mask_q != LEVEL_NMI))
      begin
         nmi_pend_d = 1'b1;
      end
      else if (take_point(state_q, boundary_in, exc_done_in) &&
               best_level == LEVEL_NMI)
      begin
         nmi_pend_d = 1'b0;
      end
      // a released line forgets its edge; a new one needs a fresh fall
      else if (!line_asserted[LEVEL_NMI])
      begin
         nmi_pend_d = 1'b0;
      end
   end

   always_comb
   begin
      state_d     = state_q;
      ack_level_d = ack_level_q;
      tmo_d       = tmo_q;
      mask_d      = mask_q;
      fc_d        = fc_q;
      addr_d      = addr_q;
      vvalid_d    = 1'b0;
      vec_d       = vec_q;
      spur_d      = 1'b0;
      pend_d      = eligible;
      if (mask_wr_in && state_q == ST_IDLE)
      begin
         mask_d = mask_wr_data_in;
      end
      case (state_q)
         ST_IDLE:
         begin
            if (take_point(state_q, boundary_in, exc_done_in) &&
                best_level != MASK_NONE)
            begin
               ack_level_d = best_level;
               mask_d      = best_level;
               fc_d        = FC_CPU_SPACE;
               addr_d      = ACK_ADDR_BASE;
               addr_d[ACK_LEVEL_LSB +: 3] = best_level;
               tmo_d       = '0;
               state_d     = ST_ACK;
            end
         end
         ST_ACK:
         begin
            tmo_d = tmo_q + 8'h01;
            if (size_ack_strobes_in)
            begin
               vec_d   = vector_data_in;
               state_d = ST_DONE;
            end
            else if (autovector_request_in)
            begin
               vec_d   = AUTOVEC_BASE + {5'h00, ack_level_q};
               state_d = ST_DONE;
            end
            else if (tmo_q == 8'(TIMEOUT_CYC - 1))
            begin
               vec_d   = SPURIOUS_VEC;
               state_d = ST_SPUR;
            end
         end
         ST_DONE:
         begin
            vvalid_d = 1'b1;
            fc_d     = '0;
            addr_d   = '0;
            state_d  = ST_IDLE;
         end
         ST_SPUR:
         begin
            vvalid_d = 1'b1;
            spur_d   = 1'b1;
            fc_d     = '0;
            addr_d   = '0;
            state_d  = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
      // registered copy keeps the strobe free of decode glitches
      ack_d = (state_d == ST_ACK);
   end

   // sample divider runs free; reset starts it in the non-sampling phase
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         fall_phase_q <= 1'b0;
      end
      else
      begin
         fall_phase_q <= fall_phase_d;
      end
   end

   // level seven memory: line, previous mask and the pending flag
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mask_prev_q  <= MASK_RESET;
         nmi_prev_q   <= 1'b0;
         nmi_pend_q   <= 1'b0;
      end
      else
      begin
         mask_prev_q  <= mask_prev_d;
         nmi_prev_q   <= nmi_prev_d;
         nmi_pend_q   <= nmi_pend_d;
      end
   end

   // acknowledge sequencer, mask and the output registers
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         mask_q       <= MASK_RESET;
         state_q      <= ST_IDLE;
         ack_q        <= 1'b0;
         ack_level_q  <= '0;
         tmo_q        <= '0;
         fc_q         <= '0;
         addr_q       <= '0;
         vvalid_q     <= 1'b0;
         vec_q        <= '0;
         spur_q       <= 1'b0;
         pend_q       <= '0;
      end
      else
      begin
         mask_q       <= mask_d;
         state_q      <= state_d;
         ack_q        <= ack_d;
         ack_level_q  <= ack_level_d;
         tmo_q        <= tmo_d;
         fc_q         <= fc_d;
         addr_q       <= addr_d;
         vvalid_q     <= vvalid_d;
         vec_q        <= vec_d;
         spur_q       <= spur_d;
         pend_q       <= pend_d;
      end
   end

   assign priority_mask_field_out = mask_q;
   assign ack_active_out          = ack_q;
   assign function_code_lines_out = fc_q;
   assign ack_addr_out            = addr_q;
   assign vector_valid_out        = vvalid_q;
   assign vector_out              = vec_q;
   assign spurious_out            = spur_q;
   assign pending_out             = pend_q;
endmodule : interrupt_request_recognition

// file: rtl/irq_recog_pkg.sv
package irq_recog_pkg;
   localparam int          NUM_LEVELS      = 7;
   localparam logic [2:0]  LEVEL_NMI       = 3'h7;
   localparam logic [2:0]  MASK_NONE       = 3'h0;
   localparam logic [2:0]  MASK_RESET      = 3'h7;
   localparam logic [2:0]  FC_CPU_SPACE    = 3'h7;
   localparam logic [23:0] ACK_ADDR_BASE   = 24'hfffff1;
   localparam int          ACK_LEVEL_LSB   = 1;
   localparam int          AUTOVEC_COUNT   = 7;
   localparam int          USER_VEC_COUNT  = 200;
   localparam logic [7:0]  AUTOVEC_BASE    = 8'h18;
   localparam logic [7:0]  SPURIOUS_VEC    = 8'h18;
   localparam logic [7:0]  USER_VEC_FIRST  = 8'h40;
   localparam int          SYNC_STAGES     = 3;
   localparam int          VALID_PERIODS   = 2;
   localparam int          ACK_TIMEOUT_CYC = 64;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ACK  = 4'h2,
      ST_DONE = 4'h4,
      ST_SPUR = 4'h8
   } ack_state_t;
endpackage : irq_recog_pkg

// file: rtl/request_qualifier.sv
`timescale 1ns/1ps
// one request line: pin synchronised, then merged with the internal source and qualified
module request_qualifier
   import irq_recog_pkg::*;
#(
   parameter int VALID_LEN = VALID_PERIODS
)(
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic sample_en_in,
   input  wire logic pin_n_in,
   input  wire logic internal_req_in,
   output logic      asserted_out
);
   logic [SYNC_STAGES-1:0] sync_q;
   logic [SYNC_STAGES-1:0] sync_d;
   logic [VALID_LEN-1:0]   hist_q;
   logic [VALID_LEN-1:0]   hist_d;
   logic                   pin_low;

   // pin low counts once the last two stages agree
   assign pin_low = ~sync_q[1] & ~sync_q[2];

   always_comb
   begin
      sync_d = {sync_q[SYNC_STAGES-2:0], pin_n_in};
      hist_d = hist_q;
      if (sample_en_in)
      begin
         hist_d = {hist_q[VALID_LEN-2:0], pin_low | internal_req_in};
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         sync_q <= '1;
         hist_q <= '0;
      end
      else
      begin
         sync_q <= sync_d;
         hist_q <= hist_d;
      end
   end

   assign asserted_out = &hist_q;
endmodule : request_qualifier

// file: tb/interrupt_request_recognition_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module interrupt_request_recognition_tb_top;
   import irq_recog_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, bnd = 1'b0, exc = 1'b0, mwr = 1'b0;
   logic [7:1] req_n = 7'h7f, int_req = 7'h00, pend;
   logic [2:0] mdata = 3'h0, mask, fc;
   logic [1:0] reply = 2'h1;
   logic sack, autovector_request, ack, vval, spur;
   logic [7:0] vdata, vec;
   logic [23:0] addr;
   int err_count = 0, checked = 0;

   initial forever #2 clk = ~clk;

   interrupt_request_recognition #(.TIMEOUT_CYC(8))
      i_interrupt_request_recognition (.clk_in(clk), .arst_n_in(rst_n),
      .request_lines_n_in(req_n), .internal_req_in(int_req),
      .boundary_in(bnd), .exc_done_in(exc), .mask_wr_in(mwr),
      .mask_wr_data_in(mdata), .size_ack_strobes_in(sack),
      .autovector_request_in(autovector_request), .vector_data_in(vdata),
      .priority_mask_field_out(mask), .ack_active_out(ack),
      .function_code_lines_out(fc), .ack_addr_out(addr),
      .vector_valid_out(vval), .vector_out(vec), .spurious_out(spur),
      .pending_out(pend));

   irq_source_model i_irq_source_model (.clk_in(clk), .ack_active_in(ack),
      .ack_addr_in(addr), .reply_in(reply), .size_ack_out(sack),
      .autovec_out(autovector_request), .vector_out(vdata));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic drive(input logic [7:1] n, input logic [7:1] i);
      @(posedge clk);
      req_n   <= n;
      int_req <= i;
   endtask : drive

   task automatic set_mask(input logic [2:0] m);
      @(posedge clk);
      mwr   <= 1'b1;
      mdata <= m;
      @(posedge clk);
      mwr   <= 1'b0;
      #1 `CHK(mask, m)
   endtask : set_mask

   // fixed wait covers sync, two samples and the pending register
   task automatic check_pend(input logic [7:1] exp);
      cyc(12);
      `CHK({ack, pend}, {1'b0, exp})
   endtask : check_pend

   task automatic do_ack(input logic by_exc, input logic [1:0] rep,
                         input logic [2:0] lvl, input logic [7:0] v);
      int n;
      @(posedge clk);
      reply <= rep;
      bnd   <= !by_exc;
      exc   <= by_exc;
      @(posedge clk);
      bnd   <= 1'b0;
      exc   <= 1'b0;
      #1;
      for (n = 0; n < 8 && ack !== 1'b1; n++) cyc(1);
      `CHK({ack, fc, addr, mask}, {1'b1, 3'h7, 20'hfffff, lvl, 1'b1, lvl})
      for (n = 0; n < 40 && vval !== 1'b1; n++) cyc(1);
      `CHK({vval, vec, spur}, {1'b1, v, rep == 2'h3})
      `CHK({fc, addr}, 27'h0)
      cyc(2);
   endtask : do_ack

   task automatic t_priority;
      set_mask(3'h0);
      drive(7'h7d, 7'h00);
      check_pend(7'h02);
      drive(7'h6d, 7'h00);
      check_pend(7'h12);
      do_ack(1'b0, 2'h1, 3'h5, 8'h45);
      check_pend(7'h00);
   endtask : t_priority

   task automatic t_internal;
      drive(7'h7d, 7'h08);
      set_mask(3'h1);
      check_pend(7'h0a);
      do_ack(1'b0, 2'h2, 3'h4, 8'h1c);
      drive(7'h7f, 7'h00);
   endtask : t_internal

   task automatic t_nmi;
      drive(7'h3f, 7'h00);
      check_pend(7'h40);
      do_ack(1'b1, 2'h3, 3'h7, 8'h18);
      check_pend(7'h00);
      set_mask(3'h3);
      check_pend(7'h40);
      do_ack(1'b0, 2'h1, 3'h7, 8'h47);
      drive(7'h7f, 7'h00);
      check_pend(7'h00);
      // two-cycle low is shorter than two sample periods
      drive(7'h3f, 7'h00);
      drive(7'h3f, 7'h00);
      drive(7'h7f, 7'h00);
      check_pend(7'h00);
      drive(7'h3f, 7'h00);
      check_pend(7'h40);
   endtask : t_nmi

   task automatic report_and_stop;
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      `CHK(mask, MASK_RESET)
      t_priority();
      t_internal();
      t_nmi();
      report_and_stop();
   end

   // the whole sequence takes well under a thousand cycles
   initial
   begin
      #40000;
      err_count++;
      report_and_stop();
   end
endmodule : interrupt_request_recognition_tb_top

// file: tb/irq_recog_chk.sv
`timescale 1ns/1ps
module irq_recog_chk
   import irq_recog_pkg::*;
#(
   parameter int TIMEOUT_CYC = ACK_TIMEOUT_CYC
)(
   input wire logic        clk_in,
   input wire logic        arst_n_in,
   input wire logic [2:0]  priority_mask_field_out,
   input wire logic        ack_active_out,
   input wire logic [2:0]  function_code_lines_out,
   input wire logic [23:0] ack_addr_out,
   input wire logic        vector_valid_out,
   input wire logic [7:0]  vector_out,
   input wire logic        spurious_out,
   input wire logic [7:1]  pending_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   logic [7:0] ack_cnt_q;
   logic [7:0] ack_cnt_d;

   always_comb ack_cnt_d = ack_active_out ? ack_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) ack_cnt_q <= 8'h00;
      else ack_cnt_q <= ack_cnt_d;

   sequence ack_close;
      !ack_active_out ##1 vector_valid_out;
   endsequence

   a_fc_cpu_space: assert property (ack_active_out |->
      function_code_lines_out == FC_CPU_SPACE) else $error("fc wrong in ack");
   a_ack_addr_level: assert property (ack_active_out |-> ack_addr_out ==
      {ACK_ADDR_BASE[23:4], priority_mask_field_out, 1'b1})
      else $error("ack address wrong");
   a_vector_after_ack: assert property ($fell(ack_active_out) |->
      ack_close) else $error("no vector after ack");
   a_valid_one_pulse: assert property (vector_valid_out |=>
      !vector_valid_out) else $error("vector valid too long");
   a_spur_vector: assert property (spurious_out |->
      vector_valid_out && vector_out == SPURIOUS_VEC) else $error("bad spur");
   a_mask_held_ack: assert property (ack_active_out ##1 ack_active_out |->
      $stable(priority_mask_field_out)) else $error("mask moved in ack");
   // levels one to six at or below the previous mask never show as pending
   a_mask_blocks_low: assert property ((pending_out[6:1] &
      ((6'h01 << $past(priority_mask_field_out)) - 6'h01)) == 6'h00)
      else $error("masked level pending");
   a_ack_bounded: assert property (ack_cnt_q <= TIMEOUT_CYC + 2)
      else $error("ack not terminated");
endmodule : irq_recog_chk

bind interrupt_request_recognition irq_recog_chk #(.TIMEOUT_CYC(TIMEOUT_CYC))
   i_irq_recog_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .priority_mask_field_out(priority_mask_field_out),
   .ack_active_out(ack_active_out), .ack_addr_out(ack_addr_out),
   .function_code_lines_out(function_code_lines_out),
   .vector_valid_out(vector_valid_out), .vector_out(vector_out),
   .spurious_out(spurious_out), .pending_out(pending_out));

// file: tb/irq_source_model.sv
`timescale 1ns/1ps
// requesting device on the acknowledge side: answers two cycles into an ack
module irq_source_model (
   input  wire logic        clk_in,
   input  wire logic        ack_active_in,
   input  wire logic [23:0] ack_addr_in,
   input  wire logic [1:0]  reply_in,
   output logic             size_ack_out,
   output logic             autovec_out,
   output logic [7:0]       vector_out
);
   logic [3:0] wait_q = 4'h0;
   logic       hit;

   initial
   begin
      size_ack_out = 1'b0;
      autovec_out  = 1'b0;
      vector_out   = 8'h00;
   end

   assign hit = ack_active_in && wait_q == 4'h2;

   // reply 1 vector, 2 autovector, 3 silent so the cycle times out
   always @(posedge clk_in)
   begin
      wait_q       <= ack_active_in ? wait_q + 4'h1 : 4'h0;
      size_ack_out <= hit && reply_in == 2'h1;
      autovec_out  <= hit && reply_in == 2'h2;
      // data bus toggles when not answering, never keeps a stale vector
      vector_out   <= hit ? 8'h40 + {5'h00, ack_addr_in[3:1]} : ~vector_out;
   end
endmodule : irq_source_model
